// ==== p0_regs.svh ====
/*
 offsets, field positions, reset values and widths of the port zero block.
 assumes byte addresses on a 32-bit ahb-lite bus, one word per register.
*/
`ifndef P0_REGS_SVH
`define P0_REGS_SVH

`define P0_ADDR_W 6
`define P0_OFS_DATA 6'h00
`define P0_OFS_DIR 6'h04
`define P0_OFS_PULLUP 6'h08
`define P0_OFS_MODE 6'h0c
`define P0_OFS_RISE 6'h10
`define P0_OFS_FALL 6'h14
`define P0_OFS_STATUS 6'h18
`define P0_OFS_MASK 6'h1c
`define P0_OFS_CTRL 6'h20
`define P0_OFS_COUNT 6'h24
`define P0_OFS_CAPTURE 6'h28

`define P0_PINS 8
`define P0_IRQS 7
`define P0_STAT_W 9
`define P0_STAT_CAP 7
`define P0_STAT_OVF 8

`define P0_CTRL_W 3
`define P0_CTRL_CAPSEL 0
`define P0_CTRL_SUBCLK 1
`define P0_CTRL_CNT_EN 2
`define P0_PULL_EN 0

`define P0_DIR_RST 8'hff
`define P0_MID_MASK 8'h7e
`define P0_END_MASK 8'h81
`define P0_PIN_SUBCLK 7
`define P0_PIN_CNT 0
`define P0_PIN_CAP 1

`endif

// ==== p0_pkg.sv ====
/*
 types shared by the port zero block and its edge detector.
 assumes p0_regs.svh is included alongside.
*/
`include "p0_regs.svh"

package p0_pkg;
    typedef logic [`P0_PINS-1:0] p0_pins_t;
    typedef logic [`P0_IRQS-1:0] p0_irqs_t;
    typedef logic [`P0_STAT_W-1:0] p0_stat_t;
    typedef logic [15:0] p0_count_t;
    typedef enum logic {P0_CAP_FROM_TRIG, P0_CAP_FROM_IRQ0} p0_capsel_t;
endpackage

// ==== p0_edge_if.sv ====
/*
 carrier between the port zero top and its edge detector.
 assumes both ends run on core_clk.
*/
`timescale 1ns/100ps

interface p0_edge_if;
    import p0_pkg::*;
    p0_irqs_t level;
    p0_irqs_t rise_en;
    p0_irqs_t fall_en;
    p0_irqs_t arm;
    p0_irqs_t valid;
    modport src (output level, output rise_en, output fall_en, output arm, input valid);
    modport det (input level, input rise_en, input fall_en, input arm, output valid);
endinterface

// ==== p0_edge_det.sv ====
/*
 valid-edge detector for the seven external interrupt inputs.
 assumes levels already synchronised to core_clk.
*/
`timescale 1ns/100ps

module p0_edge_det
    import p0_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // carrier
    p0_edge_if.det edge_io
);
    p0_irqs_t prev;
    p0_irqs_t valid;
    wire p0_irqs_t rose = edge_io.level & ~prev;
    wire p0_irqs_t fell = ~edge_io.level & prev;

    // RULE5 rising falling both
    wire p0_irqs_t next_valid = edge_io.arm &
        ((rose & edge_io.rise_en) | (fell & edge_io.fall_en));

    assign edge_io.valid = valid;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev <= '0;
            valid <= '0;
        end
        else
        begin
            prev <= edge_io.level;
            valid <= next_valid;
        end
    end
endmodule

// ==== p0_port.sv ====
/*
 port zero with alternate functions: pin control, interrupt edges,
 16-bit event counter with capture, ahb-lite register slave.
 assumes single-word ahb-lite transfers and asynchronous pin inputs.
*/
// Behaviour
// RULE1 - pin 0 and pin 7 are input-only; pins 1 to 6 can drive.
// RULE2 - each middle pin has its own direction bit in the direction register.
// RULE3 - middle pins used as inputs get a pull-up when software enables it.
// RULE4 - every pin is individually set to port mode or control mode.
// RULE5 - seven interrupt inputs detect rising, falling or both edges as selected.
// RULE6 - a valid edge on interrupt input 0 or 1 triggers timer capture.
// RULE7 - in control mode the count pin clocks the 16-bit event counter.
// RULE8 - in control mode the trigger pin loads the first capture register.
// RULE9 - the last pin can serve as subclock crystal input instead.
// RULE10 - pull-up only acts in input port mode, never while driving.
`timescale 1ns/100ps
`include "p0_regs.svh"

module p0_port
    import p0_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // port pins
    input wire logic [7:0] port_zero_pins_in,
    output logic [7:0] port_zero_pins_out,
    output logic [7:0] port_zero_pins_oe,
    output logic [7:0] port_zero_pullup_en,
    // subclock oscillator enable
    output logic subclock_crystal_in_en,
    // interrupt
    output logic irq
);
    // registers
    p0_pins_t out_latch;
    p0_pins_t port_zero_direction_reg;
    logic pullup_option_low_reg;
    p0_pins_t mode_reg;
    p0_irqs_t rise_reg;
    p0_irqs_t fall_reg;
    p0_stat_t status_reg;
    p0_stat_t mask_reg;
    logic [`P0_CTRL_W-1:0] ctrl_reg;
    p0_count_t count_reg;
    p0_count_t first_capture_register;

    // synchroniser: meta stage read only by the sync stage
    p0_pins_t pin_meta;
    p0_pins_t pin_sync;
    logic cnt_prev;

    // bus data phase bookkeeping
    logic wr_pend;
    logic [`P0_ADDR_W-1:0] wr_addr;

    function automatic p0_stat_t w1c(input p0_stat_t cur, input p0_stat_t clr,
                                     input p0_stat_t set);
        // set beats a clear landing in the same cycle
        w1c = (cur & ~clr) | set;
    endfunction

    function automatic logic [31:0] zx8(input logic [7:0] v);
        zx8 = {24'h00_0000, v};
    endfunction

    // ---- bus decode ----
    wire logic addr_phase = hsel & hready & htrans[1];
    wire logic rd_req = addr_phase & ~hwrite;
    wire logic wr_req = addr_phase & hwrite;
    wire logic [`P0_ADDR_W-1:0] rd_addr = haddr[`P0_ADDR_W-1:0];

    wire logic wr_data = wr_pend & (wr_addr == `P0_OFS_DATA);
    wire logic wr_dir = wr_pend & (wr_addr == `P0_OFS_DIR);
    wire logic wr_pull = wr_pend & (wr_addr == `P0_OFS_PULLUP);
    wire logic wr_mode = wr_pend & (wr_addr == `P0_OFS_MODE);
    wire logic wr_rise = wr_pend & (wr_addr == `P0_OFS_RISE);
    wire logic wr_fall = wr_pend & (wr_addr == `P0_OFS_FALL);
    wire logic wr_stat = wr_pend & (wr_addr == `P0_OFS_STATUS);
    wire logic wr_mask = wr_pend & (wr_addr == `P0_OFS_MASK);
    wire logic wr_ctrl = wr_pend & (wr_addr == `P0_OFS_CTRL);

    // ---- pin view ----
    // RULE9 subclock pin reads zero
    wire logic subclk_sel = ctrl_reg[`P0_CTRL_SUBCLK];
    wire p0_pins_t pin_view = subclk_sel ?
        (pin_sync & ~(8'h01 << `P0_PIN_SUBCLK)) : pin_sync;

    // RULE1 end pins never drive
    // RULE2 per-pin direction bit
    wire p0_pins_t dir_eff = port_zero_direction_reg | `P0_END_MASK;
    // RULE4 control mode pins are inputs
    wire p0_pins_t drive = ~dir_eff & ~mode_reg & `P0_MID_MASK;

    // RULE3 pull-up on input middle pins
    // RULE10 only in input port mode
    wire p0_pins_t next_pull = (pullup_option_low_reg ? `P0_MID_MASK : 8'h00) &
        dir_eff & ~mode_reg;

    // ---- external interrupts ----
    p0_edge_if edge_io ();
    assign edge_io.level = pin_view[`P0_IRQS-1:0];
    assign edge_io.rise_en = rise_reg;
    assign edge_io.fall_en = fall_reg;
    // RULE4 interrupt only in control mode
    assign edge_io.arm = mode_reg[`P0_IRQS-1:0];

    p0_edge_det u_edge (
        .core_clk (core_clk),
        .resetn (resetn),
        .edge_io (edge_io)
    );

    // ---- event counter and capture ----
    // RULE7 count pin in control mode
    wire logic cnt_level = pin_view[`P0_PIN_CNT] & mode_reg[`P0_PIN_CNT];
    wire logic cnt_tick = ctrl_reg[`P0_CTRL_CNT_EN] & cnt_level & ~cnt_prev;
    wire logic cnt_ovf = cnt_tick & (&count_reg);
    wire p0_capsel_t cap_sel = p0_capsel_t'(ctrl_reg[`P0_CTRL_CAPSEL]);

    // RULE6 valid edge from input 0 or 1
    // RULE8 trigger pin loads capture
    wire logic cap_trig = (cap_sel == P0_CAP_FROM_IRQ0) ?
        edge_io.valid[0] : edge_io.valid[`P0_PIN_CAP];
    wire p0_count_t next_count = count_reg + (cnt_tick ? 16'h0001 : 16'h0000);

    // ---- status ----
    wire p0_stat_t stat_set = {cnt_ovf, cap_trig, edge_io.valid};
    wire p0_stat_t stat_clr = wr_stat ? hwdata[`P0_STAT_W-1:0] : '0;
    wire p0_stat_t next_status = w1c(status_reg, stat_clr, stat_set);
    wire logic next_irq = |(next_status & mask_reg);

    // ---- read mux ----
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (rd_addr)
            `P0_OFS_DATA: next_rdata = zx8(pin_view);
            `P0_OFS_DIR: next_rdata = zx8(dir_eff);
            `P0_OFS_PULLUP: next_rdata = {31'h0000_0000, pullup_option_low_reg};
            `P0_OFS_MODE: next_rdata = zx8(mode_reg);
            `P0_OFS_RISE: next_rdata = {25'h000_0000, rise_reg};
            `P0_OFS_FALL: next_rdata = {25'h000_0000, fall_reg};
            `P0_OFS_STATUS: next_rdata = {23'h00_0000, status_reg};
            `P0_OFS_MASK: next_rdata = {23'h00_0000, mask_reg};
            `P0_OFS_CTRL: next_rdata = {29'h0000_0000, ctrl_reg};
            `P0_OFS_COUNT: next_rdata = {16'h0000, count_reg};
            `P0_OFS_CAPTURE: next_rdata = {16'h0000, first_capture_register};
            // unmapped words read zero, answer stays okay
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // ---- bus phase ----
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            // zero wait states, so read data is taken in the address phase
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_req)
            begin
                hrdata <= next_rdata;
            end
        end
    end

    // ---- write data phase ----
    // writes land one cycle later, when hwdata stands
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end
        else
        begin
            wr_pend <= wr_req;
            if (wr_req)
            begin
                wr_addr <= haddr[`P0_ADDR_W-1:0];
            end
        end
    end

    // ---- configuration registers ----
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_latch <= '0;
            port_zero_direction_reg <= `P0_DIR_RST;
            pullup_option_low_reg <= 1'b0;
            mode_reg <= '0;
        end
        else
        begin
            if (wr_data)
            begin
                out_latch <= hwdata[7:0] & `P0_MID_MASK;
            end
            // RULE2 direction per bit
            if (wr_dir)
            begin
                port_zero_direction_reg <= hwdata[7:0] | `P0_END_MASK;
            end
            if (wr_pull)
            begin
                pullup_option_low_reg <= hwdata[`P0_PULL_EN];
            end
            // RULE4 per-pin mode select
            if (wr_mode)
            begin
                mode_reg <= hwdata[7:0];
            end
        end
    end

    // ---- edge select registers ----
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rise_reg <= '0;
            fall_reg <= '0;
        end
        else
        begin
            // RULE5 edge selection
            if (wr_rise)
            begin
                rise_reg <= hwdata[`P0_IRQS-1:0];
            end
            if (wr_fall)
            begin
                fall_reg <= hwdata[`P0_IRQS-1:0];
            end
        end
    end

    // ---- mask and control registers ----
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mask_reg <= '0;
            ctrl_reg <= '0;
        end
        else
        begin
            if (wr_mask)
            begin
                mask_reg <= hwdata[`P0_STAT_W-1:0];
            end
            if (wr_ctrl)
            begin
                ctrl_reg <= hwdata[`P0_CTRL_W-1:0];
            end
        end
    end

    // ---- synchroniser ----
    // two flops, the pins are not timed to core_clk
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= port_zero_pins_in;
            pin_sync <= pin_meta;
        end
    end

    // ---- pin outputs ----
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            port_zero_pins_out <= '0;
            port_zero_pins_oe <= '0;
            port_zero_pullup_en <= '0;
            subclock_crystal_in_en <= 1'b0;
        end
        else
        begin
            // RULE1 only middle pins drive
            port_zero_pins_out <= out_latch & drive;
            port_zero_pins_oe <= drive;
            // RULE10 pull-up off while driving
            port_zero_pullup_en <= next_pull;
            // RULE9 crystal input select
            subclock_crystal_in_en <= subclk_sel;
        end
    end

    // ---- counter and capture ----
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_prev <= 1'b0;
            count_reg <= '0;
            first_capture_register <= '0;
        end
        else
        begin
            cnt_prev <= cnt_level;
            // RULE7 count on rising edge
            count_reg <= next_count;
            // RULE8 capture current count
            if (cap_trig)
            begin
                first_capture_register <= count_reg;
            end
        end
    end

    // ---- status and interrupt ----
    // irq taken from next_status so it rises with the status bit
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            status_reg <= next_status;
            irq <= next_irq;
        end
    end
endmodule

// ==== p0_port_sva.sv ====
/*
 assertions on the p0_port ports.
 assumes a bind onto p0_port and one-word ahb-lite transfers.
*/
`timescale 1ns/100ps
`include "p0_regs.svh"
module p0_port_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // pins
    input wire logic [7:0] port_zero_pins_out,
    input wire logic [7:0] port_zero_pins_oe,
    input wire logic [7:0] port_zero_pullup_en,
    input wire logic subclock_crystal_in_en,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire take = hsel && hready && htrans[1];
    wire wr = take && hwrite;
    wire [5:0] a = haddr[5:0];
    wire sub_bit = hwdata[`P0_CTRL_SUBCLK];
    wire [31:0] oe = {24'h0, port_zero_pins_oe};
    wire [31:0] pu = {24'h0, port_zero_pullup_en};
    wire [31:0] dout = {24'h0, port_zero_pins_out};
    AST_END_IN: assert property (port_zero_pins_oe[0] == 1'b0 && !port_zero_pins_oe[7])
        else $error("end pin driven");
    AST_DIR: assert property (wr && a == `P0_OFS_DIR |-> ##3 (oe & $past(hwdata, 2)) == 0)
        else $error("input pin driven");
    AST_OUT: assert property (wr && a == `P0_OFS_DATA |-> ##3 (dout & oe) == ($past(hwdata, 2) & oe))
        else $error("pin value wrong");
    AST_MODE: assert property (wr && a == `P0_OFS_MODE |-> ##3 ((oe | pu) & $past(hwdata, 2)) == 0)
        else $error("control pin driven or pulled");
    AST_PULL: assert property ((pu & oe) == 0 && (pu & 32'h81) == 0)
        else $error("pull-up while driving");
    AST_SUB: assert property (wr && a == `P0_OFS_CTRL |-> ##3 subclock_crystal_in_en == $past(sub_bit, 2))
        else $error("subclock enable wrong");
    AST_MASK: assert property (wr && a == `P0_OFS_MASK ##1 hwdata == 0 |-> ##2 !irq)
        else $error("irq while masked");
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    AST_UNMAP: assert property (take && !hwrite && a == 6'h3c |=> hrdata == 0)
        else $error("unmapped read not zero");
    cover property (irq);
    cover property (wr && a == `P0_OFS_DIR);
    cover property ($rose(subclock_crystal_in_en));
endmodule
bind p0_port p0_port_sva chk_u (.*);

// ==== p0_pins_model.sv ====
/*
 pin levels seen by the port: port drive, outside sources, pull-ups.
 assumes outside sources never fight a driven pin.
*/
`timescale 1ns/100ps
module p0_pins_model (
    // clock
    input wire logic core_clk,
    // port side
    input wire logic [7:0] pins_out,
    input wire logic [7:0] pins_oe,
    input wire logic [7:0] pull_en,
    // outside sources
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_level,
    // resolved levels
    output logic [7:0] pins_in
);
    logic flip = 1'b0;
    wire [7:0] float = ~pins_oe & ~ext_drive;
    // undriven pins without a pull-up wander so a stale level never passes
    always @(posedge core_clk) flip <= !flip;
    assign pins_in = (pins_oe & pins_out) | (ext_drive & ~pins_oe & ext_level)
        | (float & (pull_en | {4{flip, !flip}}));
endmodule

// ==== tb.sv ====
/*
 bench for p0_port: register table, then pin, edge, counter, subclock cases.
 assumes p0_pins_model on the pins and the checker bound in.
*/
`timescale 1ns/100ps
`include "p0_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    typedef struct packed {logic [5:0] a; logic w; logic [31:0] d; logic [31:0] e;} p0_row_t;
    logic core_clk = 0, resetn = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rdat;
    logic [7:0] ext_drive = 8'hff, ext_level = 8'h00;
    wire hready, hresp, irq, sub_en;
    wire [31:0] hrdata;
    wire [7:0] p_in, p_out, p_oe, p_pu;
    int checks = 0, mismatches = 0, cyc = 0;
    p0_row_t rows [13] = '{
        '{`P0_OFS_DIR, 1'b0, 32'h0, 32'hff}, '{`P0_OFS_MODE, 1'b0, 32'h0, 32'h0},
        '{`P0_OFS_STATUS, 1'b0, 32'h0, 32'h0}, '{`P0_OFS_CAPTURE, 1'b0, 32'h0, 32'h0},
        '{6'h3c, 1'b1, 32'hffffffff, 32'h0}, '{`P0_OFS_DIR, 1'b1, 32'h0, 32'h81},
        '{`P0_OFS_MODE, 1'b1, 32'hffffffff, 32'hff}, '{`P0_OFS_RISE, 1'b1, 32'hffffffff, 32'h7f},
        '{`P0_OFS_FALL, 1'b1, 32'hffffffff, 32'h7f}, '{`P0_OFS_MASK, 1'b1, 32'hffffffff, 32'h1ff},
        '{`P0_OFS_PULLUP, 1'b1, 32'hffffffff, 32'h1}, '{`P0_OFS_CTRL, 1'b1, 32'hffffffff, 32'h7},
        '{`P0_OFS_COUNT, 1'b1, 32'hffffffff, 32'h0}};
    initial forever #4 core_clk = ~core_clk;
    p0_port dut_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .port_zero_pins_in(p_in),
        .port_zero_pins_out(p_out), .port_zero_pins_oe(p_oe), .port_zero_pullup_en(p_pu),
        .subclock_crystal_in_en(sub_en), .irq(irq));
    p0_pins_model pm_u (.core_clk(core_clk), .pins_out(p_out), .pins_oe(p_oe),
        .pull_en(p_pu), .ext_drive(ext_drive), .ext_level(ext_level), .pins_in(p_in));
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(a, 1'b0, 32'h0);
    endtask
    // level held well past the two-cycle minimum and the status latency
    task automatic pin(input int i, input logic v);
        logic [7:0] lvl;
        @(posedge core_clk);
        lvl = ext_level;
        lvl[i] = v;
        ext_level <= lvl;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        int s;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        `CHK("oe", 8'h0, p_oe);
        foreach (rows[k])
        begin
            if (rows[k].w)
                wr(rows[k].a, rows[k].d);
            rd(rows[k].a);
            `CHK("reg", rows[k].e, rdat);
        end
        $display("test regs done");
        ext_drive <= 8'h81;
        wr(`P0_OFS_MODE, 0);
        wr(`P0_OFS_CTRL, 0);
        wr(`P0_OFS_DIR, 32'ha5);
        wr(`P0_OFS_DATA, 32'hff);
        // driven levels pass the pin drive flop and two sync flops
        repeat (2) @(posedge core_clk);
        rd(`P0_OFS_DATA);
        `CHK("oe", 8'h5a, p_oe);
        `CHK("out", 8'h5a, p_out & p_oe);
        `CHK("pull", 8'h24, p_pu);
        `CHK("data", 32'h7e, rdat);
        wr(`P0_OFS_MODE, 32'h0c);
        rd(`P0_OFS_MODE);
        `CHK("oe mode", 8'h52, p_oe);
        `CHK("pull mode", 8'h20, p_pu);
        $display("test pins done");
        ext_drive <= 8'hff;
        wr(`P0_OFS_DIR, 32'hff);
        wr(`P0_OFS_MODE, 32'hff);
        wr(`P0_OFS_MASK, 32'h7f);
        wr(`P0_OFS_STATUS, 32'h1ff);
        for (int i = 0; i < 7; i++)
        begin
            s = i % 3;
            wr(`P0_OFS_RISE, 32'(s != 1) << i);
            wr(`P0_OFS_FALL, 32'(s != 0) << i);
            pin(i, 1'b1);
            rd(`P0_OFS_STATUS);
            `CHK("rise", 32'(s != 1) << i, rdat & 32'h7f);
            `CHK("irq", s != 1, irq);
            wr(`P0_OFS_STATUS, 32'h1ff);
            pin(i, 1'b0);
            rd(`P0_OFS_STATUS);
            `CHK("fall", 32'(s != 0) << i, rdat & 32'h7f);
            wr(`P0_OFS_STATUS, 32'h1ff);
        end
        wr(`P0_OFS_MODE, 32'h7b);
        wr(`P0_OFS_RISE, 32'h7f);
        pin(2, 1'b1);
        rd(`P0_OFS_STATUS);
        `CHK("port mode edge", 32'h0, rdat);
        wr(`P0_OFS_MASK, 32'h0);
        $display("test edges done");
        wr(`P0_OFS_MODE, 32'hff);
        wr(`P0_OFS_RISE, 32'h02);
        wr(`P0_OFS_FALL, 32'h0);
        wr(`P0_OFS_STATUS, 32'h1ff);
        wr(`P0_OFS_CTRL, 32'h4);
        repeat (5)
        begin
            pin(0, 1'b1);
            pin(0, 1'b0);
        end
        rd(`P0_OFS_COUNT);
        `CHK("count", 32'h5, rdat);
        pin(1, 1'b1);
        rd(`P0_OFS_CAPTURE);
        `CHK("capture", 32'h5, rdat);
        rd(`P0_OFS_STATUS);
        `CHK("cap flag", 32'h80, rdat & 32'h180);
        wr(`P0_OFS_STATUS, 32'h1ff);
        wr(`P0_OFS_CTRL, 32'h5);
        wr(`P0_OFS_RISE, 32'h3);
        pin(1, 1'b0);
        pin(1, 1'b1);
        rd(`P0_OFS_STATUS);
        `CHK("cap ignored", 32'h0, rdat & 32'h180);
        pin(0, 1'b1);
        rd(`P0_OFS_STATUS);
        `CHK("cap irq0", 32'h80, rdat & 32'h180);
        rd(`P0_OFS_COUNT);
        `CHK("count", 32'h6, rdat);
        $display("test counter done");
        wr(`P0_OFS_CTRL, 32'h2);
        pin(7, 1'b1);
        rd(`P0_OFS_DATA);
        `CHK("sub en", 1'b1, sub_en);
        `CHK("sub pin", 1'b0, rdat[7]);
        wr(`P0_OFS_CTRL, 32'h0);
        rd(`P0_OFS_DATA);
        `CHK("pin7", 1'b1, rdat[7]);
        $display("test subclock done");
        resetn <= 1'b0;
        @(posedge core_clk);
        resetn <= 1'b1;
        rd(`P0_OFS_MODE);
        `CHK("mode reset", 32'h0, rdat);
        rd(`P0_OFS_RISE);
        `CHK("rise reset", 32'h0, rdat);
        $display("test reset done");
        stop_test();
    end
endmodule
